// File: pgd_pkg.sv
// Register map, field layout, carrier types and timing constants of the clock gating block.
package pgd_pkg;
  // ************************************************************
  // Structure
  // ************************************************************
  localparam int NUM_OUT = 12;
  localparam int IDX_REG0 = 4;
  localparam int IDX_EXT0 = 8;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MULT = 8'h04;
  localparam logic [7:0] ADDR_GATE = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_DIV0 = 8'h10;
  localparam logic [7:0] ADDR_DIVN = 8'h3C;
  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int CTRL_GOVERNED = 0;
  localparam int CTRL_ARESET = 1;
  localparam int CTRL_PFD_EN = 2;
  localparam int CTRL_EXT_FB = 3;
  localparam int CTRL_PFD_LOSS = 4;
  localparam logic [4:0] CTRL_RESET = 5'h05;
  localparam logic [5:0] MULT_RESET = 6'h01;
  localparam logic [11:0] GATE_RESET = 12'hFFF;
  localparam int DIV_HI_LSB = 0;
  localparam int DIV_LO_LSB = 8;
  localparam int DIV_BYP_BIT = 16;
  localparam logic [5:0] DIV_CNT_RESET = 6'h01;
  localparam int STAT_LOCK = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_VCO_LSB = 8;
  localparam int STAT_GATE_LSB = 16;
  localparam logic [5:0] DIV_MIN = 6'h01;
  localparam logic [5:0] DIV_MAX = 6'h20;
  // ************************************************************
  // Oscillator model and timing counts
  // ************************************************************
  localparam int NOM_VCO_MHZ = 700;
  localparam int VCO_MHZ_PER_CODE = 8;
  localparam logic [7:0] NOM_CODE = 8'(NOM_VCO_MHZ / VCO_MHZ_PER_CODE);
  localparam logic [7:0] TGT_STEP = 8'h04;
  localparam logic [3:0] LOCK_HOLD = 4'h8;
  localparam logic [7:0] DRIFT_CYCLES = 8'hFF;
  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic byp;
    logic [5:0] lo;
    logic [5:0] hi;
  } pgd_div_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pgd_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pgd_apb_rsp_s;
  // Forces a count into the legal 1..32 range.
  function automatic logic [5:0] pgd_clamp(input logic [5:0] v);
    if (v < DIV_MIN) begin
      return DIV_MIN;
    end
    if (v > DIV_MAX) begin
      return DIV_MAX;
    end
    return v;
  endfunction
endpackage

// File: pgd_post_counter.sv
// Post-scale counter with separate high and low counts.
`timescale 1ns/1ps
module pgd_post_counter
  import pgd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Oscillator timing
  input wire logic tick,
  input wire logic vco_phase,
  input wire logic clr,
  input wire pgd_pkg::pgd_div_s cfg,
  // Counter output
  output logic q,
  output logic fall
);
  import pgd_pkg::*;

  typedef struct packed {
    logic moved;
    pgd_div_s cfg_d;
    logic [5:0] cnt;
    logic q;
    logic fall;
  } pgd_cnt_state_s;
  pgd_cnt_state_s st;
  pgd_cnt_state_s next_st;
  logic [5:0] cnt_inc;

  assign cnt_inc = 6'(st.cnt + 6'h01);

  always_comb begin
    next_st = st;
    if (clr) begin
      next_st.cnt = '0;
      next_st.q = 1'b0;
    end else if (cfg.byp) begin
      next_st.cnt = '0;
      next_st.q = vco_phase;
    end else if (tick) begin
      if (cnt_inc >= (st.q ? cfg.hi : cfg.lo)) begin
        next_st.q = ~st.q;
        next_st.cnt = '0;
      end else begin
        next_st.cnt = cnt_inc;
      end
    end
    next_st.fall = st.q & ~next_st.q;
    // A count rewritten mid-phase may already be passed; that phase ends at the next tick.
    next_st.cfg_d = cfg;
    next_st.moved = (st.moved | (cfg != st.cfg_d)) & ~clr & ~cfg.byp & (next_st.q == st.q);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;
  assign fall = st.fall;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_high_time;
    $fell(st.q) && $past(!clr) && $past(!cfg.byp) && $past(!st.moved)
      && $past(cfg.hi) == $past(cfg.hi, 2)
      |-> 6'($past(st.cnt) + 6'h01) == $past(cfg.hi);
  endproperty
  a_high_time: assert property (p_high_time) else $error("high time differs");
  property p_low_time;
    $rose(st.q) && $past(!cfg.byp) && $past(!st.moved) && $past(cfg.lo) == $past(cfg.lo, 2)
      |-> 6'($past(st.cnt) + 6'h01) == $past(cfg.lo);
  endproperty
  a_low_time: assert property (p_low_time) else $error("low time differs");
  property p_bypass;
    !clr && cfg.byp |=> st.q == $past(vco_phase);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not passing");
endmodule

// File: pgd_clock_ctrl.sv
// Synthesizer control: enable, reset, phase detector gate, dividers and output gating.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module pgd_clock_ctrl
  import pgd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire pgd_pkg::pgd_apb_req_s apb_req,
  output pgd_pkg::pgd_apb_rsp_s apb_rsp,
  // Device pins and reference status
  input wire logic pll_enable_pin,
  input wire logic ref_tick,
  input wire logic ref_loss,
  // Synthesized clocks and lock indication
  output logic [11:0] clk_out,
  output logic lock
);
  import pgd_pkg::*;

  typedef struct packed {
    logic [4:0] ctrl;
    logic [5:0] mult;
    logic [11:0] gate_req;
    pgd_div_s [11:0] div;
    logic [11:0] gate_on;
    logic [11:0] clk_out;
    logic lock;
    logic [3:0] lock_cnt;
    logic [7:0] vco_code;
    logic [7:0] acc;
    logic vco_phase;
    logic [7:0] drift_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pgd_state_s;

  pgd_state_s st;
  pgd_state_s next_st;

  // ************************************************************
  // Run control and oscillator model
  // ************************************************************
  logic governed_off;
  logic run;
  logic pfd_eff;
  logic [7:0] target;
  logic [8:0] acc_sum;
  logic vco_tick;
  logic [11:0] cnt_q;
  logic [11:0] cnt_fall;
  pgd_div_s [11:0] cfg;

  // The enable pin only matters while this synthesizer is marked governed, as it is from reset.
  assign governed_off = st.ctrl[CTRL_GOVERNED] & ~pll_enable_pin;
  assign run = ~st.ctrl[CTRL_ARESET] & ~governed_off;
  assign pfd_eff = st.ctrl[CTRL_PFD_LOSS] ? ~ref_loss : st.ctrl[CTRL_PFD_EN];
  // One multiplier feeds every output, so only one serial rate can exist.
  assign target = 8'({2'b00, pgd_clamp(st.mult)} * TGT_STEP);
  assign acc_sum = {1'b0, st.acc} + {1'b0, st.vco_code};
  assign vco_tick = acc_sum[8] & run;

  // ************************************************************
  // Post-scale counters
  // ************************************************************
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      cfg[i].byp = st.div[i].byp;
      cfg[i].hi = pgd_clamp(st.div[i].hi);
      cfg[i].lo = pgd_clamp(st.div[i].lo);
    end
  end

  for (genvar g = 0; g < NUM_OUT; g++) begin : gen_cnt
    // Counters restart together on release, which keeps output phases aligned.
    pgd_post_counter u_cnt (
      .core_clk(core_clk),
      .rst(rst),
      .tick(vco_tick),
      .vco_phase(st.vco_phase),
      .clr(~run),
      .cfg(cfg[g]),
      .q(cnt_q[g]),
      .fall(cnt_fall[g])
    );
  end

  // ************************************************************
  // Register access
  // ************************************************************
  logic acc_phase;
  logic mapped;
  logic [3:0] div_idx;
  logic [7:0] div_off;

  assign acc_phase = apb_req.psel & apb_req.penable;
  assign mapped = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr <= ADDR_DIVN);
  assign div_off = 8'(apb_req.paddr - ADDR_DIV0);
  assign div_idx = div_off[5:2];

  function automatic logic [31:0] pack_div(input pgd_div_s d);
    logic [31:0] w;
    w = '0;
    w[DIV_HI_LSB +: 6] = d.hi;
    w[DIV_LO_LSB +: 6] = d.lo;
    w[DIV_BYP_BIT] = d.byp;
    return w;
  endfunction

  function automatic logic [31:0] read_word(input pgd_state_s s, input logic [7:0] a,
                                           input logic [3:0] idx, input logic r);
    logic [31:0] w;
    w = '0;
    case (a)
      ADDR_CTRL: w[4:0] = s.ctrl;
      ADDR_MULT: w[5:0] = s.mult;
      ADDR_GATE: w[11:0] = s.gate_req;
      ADDR_STAT: begin
        w[STAT_LOCK] = s.lock;
        w[STAT_RUN] = r;
        w[STAT_VCO_LSB +: 8] = s.vco_code;
        w[STAT_GATE_LSB +: 12] = s.gate_on;
      end
      default: begin
        if (a >= ADDR_DIV0 && a <= ADDR_DIVN) begin
          w = pack_div(s.div[idx]);
        end
      end
    endcase
    return w;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;
    // One wait state: the answer is raised after the first access cycle.
    next_st.pready = acc_phase & ~st.pready;
    if (acc_phase && !st.pready) begin
      next_st.prdata = read_word(st, apb_req.paddr, div_idx, run);
      next_st.pslverr = ~mapped;
    end
    if (acc_phase && st.pready && apb_req.pwrite && mapped) begin
      case (apb_req.paddr)
        ADDR_CTRL: next_st.ctrl = apb_req.pwdata[4:0];
        ADDR_MULT: next_st.mult = apb_req.pwdata[5:0];
        ADDR_GATE: next_st.gate_req = apb_req.pwdata[11:0];
        ADDR_STAT: next_st.ctrl = st.ctrl;
        default: begin
          if (apb_req.paddr >= ADDR_DIV0) begin
            next_st.div[div_idx].hi = apb_req.pwdata[DIV_HI_LSB +: 6];
            next_st.div[div_idx].lo = apb_req.pwdata[DIV_LO_LSB +: 6];
            next_st.div[div_idx].byp = apb_req.pwdata[DIV_BYP_BIT];
          end
        end
      endcase
    end

    // Oscillator, phase detector and lock.
    if (st.ctrl[CTRL_ARESET]) begin
      next_st.vco_code = NOM_CODE;
      next_st.acc = '0;
      next_st.vco_phase = 1'b0;
      next_st.lock = 1'b0;
      next_st.lock_cnt = '0;
      next_st.drift_cnt = '0;
    end else if (!run) begin
      next_st.lock = 1'b0;
      next_st.lock_cnt = '0;
    end else begin
      next_st.acc = acc_sum[7:0];
      if (vco_tick) begin
        next_st.vco_phase = ~st.vco_phase;
      end
      if (pfd_eff) begin
        next_st.drift_cnt = '0;
        if (ref_tick) begin
          // Starting above target after reset gives the frequency overshoot.
          if (st.vco_code < target) begin
            next_st.vco_code = 8'(st.vco_code + 8'h01);
            next_st.lock = 1'b0;
            next_st.lock_cnt = '0;
          end else if (st.vco_code > target) begin
            next_st.vco_code = 8'(st.vco_code - 8'h01);
            next_st.lock = 1'b0;
            next_st.lock_cnt = '0;
          end else if (st.lock_cnt == LOCK_HOLD) begin
            next_st.lock = 1'b1;
          end else begin
            next_st.lock_cnt = 4'(st.lock_cnt + 4'h1);
          end
        end
      end else begin
        // Control held; counters keep running while the frequency drifts down one code every 256 cycles.
        next_st.lock = 1'b0;
        next_st.lock_cnt = '0;
        next_st.drift_cnt = 8'(st.drift_cnt + 8'h01);
        if (st.drift_cnt == DRIFT_CYCLES && st.vco_code > 8'h01) begin
          next_st.vco_code = 8'(st.vco_code - 8'h01);
        end
      end
    end

    // Gates change only while the counter output is low, so no pulse is cut.
    for (int i = 0; i < NUM_OUT; i++) begin
      if (cnt_fall[i] || !run) begin
        next_st.gate_on[i] = st.gate_req[i];
      end
      next_st.clk_out[i] = run & cnt_q[i] & st.gate_on[i];
    end
    // Gating leaves the loop alone, except the fed-back external counter.
    if (st.ctrl[CTRL_EXT_FB] && !st.gate_on[IDX_EXT0] && next_st.gate_on[IDX_EXT0]) begin
      next_st.lock = 1'b0;
      next_st.lock_cnt = '0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.mult <= MULT_RESET;
      st.gate_req <= GATE_RESET;
      st.vco_code <= NOM_CODE;
      for (int i = 0; i < NUM_OUT; i++) begin
        st.div[i].hi <= DIV_CNT_RESET;
        st.div[i].lo <= DIV_CNT_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp.prdata = st.prdata;
  assign apb_rsp.pready = st.pready;
  assign apb_rsp.pslverr = st.pslverr;
  assign clk_out = st.clk_out;
  assign lock = st.lock;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_enable_low;
    governed_off |=> st.clk_out == 12'h000 && !st.lock;
  endproperty
  a_enable_low: assert property (p_enable_low) else $error("outputs live with enable low");
  property p_areset;
    st.ctrl[CTRL_ARESET] |=> st.vco_code == NOM_CODE && !st.lock && st.clk_out == 12'h000;
  endproperty
  a_areset: assert property (p_areset) else $error("reset did not restore nominal");
  property p_gate_at_fall;
    $changed(st.gate_on[0]) |-> $past(cnt_fall[0]) || $past(!run);
  endproperty
  a_gate_at_fall: assert property (p_gate_at_fall) else $error("gate changed mid pulse");
  property p_gate_pass;
    run && st.gate_on[IDX_REG0] |=> st.clk_out[IDX_REG0] == $past(cnt_q[IDX_REG0]);
  endproperty
  a_gate_pass: assert property (p_gate_pass) else $error("enabled output not passing");
  property p_ext_relock;
    $rose(st.gate_on[IDX_EXT0]) && $past(st.ctrl[CTRL_EXT_FB]) |-> !st.lock;
  endproperty
  a_ext_relock: assert property (p_ext_relock) else $error("no relock on re-enable");
  property p_lock_on_target;
    $rose(st.lock) |-> st.vco_code == $past(target) && $past(st.lock_cnt) == LOCK_HOLD;
  endproperty
  a_lock_on_target: assert property (p_lock_on_target) else $error("lock off target");
  property p_pfd_hold;
    !pfd_eff && run && $past(!pfd_eff) && $past(run) |-> st.vco_code <= $past(st.vco_code);
  endproperty
  a_pfd_hold: assert property (p_pfd_hold) else $error("oscillator rose with detector off");
  property p_pfd_lock_off;
    !pfd_eff |=> !st.lock;
  endproperty
  a_pfd_lock_off: assert property (p_pfd_lock_off) else $error("lock kept with detector off");
  // A closed gate must block its port even while the counter keeps running.
  property p_gate_block;
    !st.gate_on[0] |=> !st.clk_out[0];
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("closed gate passed a pulse");
  property p_gate_stopped;
    !run |=> st.gate_on == $past(st.gate_req);
  endproperty
  a_gate_stopped: assert property (p_gate_stopped) else $error("gate not taken while stopped");
  property p_reg_gate_at_fall;
    $changed(st.gate_on[IDX_REG0]) |-> $past(cnt_fall[IDX_REG0]) || $past(!run);
  endproperty
  a_reg_gate_at_fall: assert property (p_reg_gate_at_fall) else $error("regional gate mid pulse");
  property p_ext_gate_block;
    !st.gate_on[IDX_EXT0] |=> !st.clk_out[IDX_EXT0];
  endproperty
  a_ext_gate_block: assert property (p_ext_gate_block) else $error("external gate leaked");
  property p_ext_gate_at_fall;
    $changed(st.gate_on[IDX_EXT0]) |-> $past(cnt_fall[IDX_EXT0]) || $past(!run);
  endproperty
  a_ext_gate_at_fall: assert property (p_ext_gate_at_fall) else $error("external gate mid pulse");
  property p_gate_keeps_lock;
    st.lock && run && pfd_eff && !st.ctrl[CTRL_EXT_FB] && st.vco_code == target |=> st.lock;
  endproperty
  a_gate_keeps_lock: assert property (p_gate_keeps_lock) else $error("lock lost while on target");
  property p_lock_range;
    st.lock |-> st.vco_code >= TGT_STEP && st.vco_code <= 8'({2'b00, DIV_MAX} * TGT_STEP);
  endproperty
  a_lock_range: assert property (p_lock_range) else $error("lock outside multiplier range");
  property p_areset_counters;
    st.ctrl[CTRL_ARESET] |=> cnt_q == 12'h000;
  endproperty
  a_areset_counters: assert property (p_areset_counters) else $error("counters not cleared");
  property p_release_low;
    $fell(st.ctrl[CTRL_ARESET]) |-> cnt_q == 12'h000;
  endproperty
  a_release_low: assert property (p_release_low) else $error("counters not restarted together");

  c_lock: cover property ($rose(st.lock));
  c_ext_relock: cover property ($rose(st.gate_on[IDX_EXT0]) && st.ctrl[CTRL_EXT_FB]);
  c_bypass: cover property (st.div[IDX_REG0].byp && run);
  c_gate_cycle: cover property ($fell(st.gate_on[0]) ##[1:200] $rose(st.gate_on[0]));
  c_areset: cover property (st.ctrl[CTRL_ARESET] ##1 !st.ctrl[CTRL_ARESET]);
endmodule

// File: pgd_fabric_model.sv
// Fabric-side model that supplies reference ticks and the clock loss flag.
`timescale 1ns/1ps
module pgd_fabric_model #(
  parameter int REF_DIV = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Scenario control
  input wire logic ref_stop,
  // Reference status toward the block
  output logic ref_tick,
  output logic ref_loss
);
  int cnt;
  // ************************************************************
  // Reference generation
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      ref_tick <= 1'b0;
      ref_loss <= 1'b0;
    end else begin
      cnt <= (cnt == REF_DIV - 1) ? 0 : cnt + 1;
      ref_tick <= !ref_stop && cnt == 0;
      // The flag follows the missing reference so that it can gate the detector.
      ref_loss <= ref_stop;
    end
  end
endmodule

// File: tb_pll_output_gating_and_dividers.sv
// Self-checking testbench of the clock gating and divider control block.
`timescale 1ns/1ps
module tb_pll_output_gating_and_dividers;
  import pgd_pkg::*;
  logic core_clk, rst, pll_enable_pin, ref_stop, ref_tick, ref_loss, lock;
  logic [11:0] clk_out, tog;
  pgd_apb_req_s req;
  pgd_apb_rsp_s rsp;
  logic [64:0] notes[$];
  logic [64:0] nt;
  logic [31:0] seed, d;
  int fails, n_checks, hi0;
  pgd_clock_ctrl i_pgd_clock_ctrl (.core_clk(core_clk), .rst(rst), .apb_req(req),
    .apb_rsp(rsp), .pll_enable_pin(pll_enable_pin), .ref_tick(ref_tick),
    .ref_loss(ref_loss), .clk_out(clk_out), .lock(lock));
  pgd_fabric_model i_pgd_fabric_model (.core_clk(core_clk), .rst(rst), .ref_stop(ref_stop),
    .ref_tick(ref_tick), .ref_loss(ref_loss));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Expected read data and error flag are queued; the monitor below compares them.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv,
                     input logic [31:0] msk, input logic err);
    int k;
    notes.push_back({err, msk, dv});
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= dv;
    @(posedge core_clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      check(32'h0, 32'h1);
      conclude();
    end
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic watch(input int n);
    logic [11:0] prev;
    prev = clk_out;
    tog = '0;
    hi0 = 0;
    repeat (n) begin
      @(posedge core_clk);
      tog = tog | (prev ^ clk_out);
      prev = clk_out;
      hi0 += int'(clk_out[0]);
    end
  endtask
  task automatic wait_lock(input logic v);
    int k;
    k = 0;
    while (lock !== v && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    check({31'h0, lock}, {31'h0, v});
    if (k >= 4000) begin
      conclude();
    end
  endtask
  // ************************************************************
  // Response monitor
  // ************************************************************
  always @(posedge core_clk) begin
    if (rsp.pready === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        nt = notes.pop_front();
        check(rsp.prdata & nt[63:32], nt[31:0] & nt[63:32]);
        check({31'h0, rsp.pslverr}, {31'h0, nt[64]});
      end
    end
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    rst = 1'b1;
    pll_enable_pin = 1'b1;
    ref_stop = 1'b0;
    req = '0;
    seed = 32'hB743;
    fails = 0;
    n_checks = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, ADDR_CTRL, 32'h5, '1, 1'b0);
    apb(1'b0, ADDR_GATE, 32'hFFF, '1, 1'b0);
    apb(1'b0, ADDR_DIV0, 32'h101, '1, 1'b0);
    apb(1'b0, 8'h40, 32'h0, '1, 1'b1);
    apb(1'b1, 8'h02, 32'h5, '0, 1'b1);
    apb(1'b1, ADDR_MULT, 32'h0, '0, 1'b0);
    apb(1'b0, ADDR_MULT, 32'h0, '1, 1'b0);
    for (int i = 0; i < NUM_OUT; i++) begin
      seed = xs(seed);
      d = {17'h0, 1'b0, seed[12:8] + 5'h1 == 5'h0, seed[12:8] + 5'h1, 2'h0,
           seed[4:0] + 5'h1 == 5'h0, seed[4:0] + 5'h1};
      apb(1'b1, ADDR_DIV0 + 8'(4 * i), d, '0, 1'b0);
      apb(1'b0, ADDR_DIV0 + 8'(4 * i), d, '1, 1'b0);
    end
    apb(1'b1, ADDR_DIV0, 32'h503, '0, 1'b0);
    apb(1'b1, ADDR_MULT, 32'd22, '0, 1'b0);
    wait_lock(1'b1);
    watch(2048);
    check({31'h0, hi0 * 8 > 3 * 2048 - 256 && hi0 * 8 < 3 * 2048 + 256}, 32'h1);
    apb(1'b1, ADDR_GATE, 32'hFFE, '0, 1'b0);
    watch(100);
    watch(600);
    check({20'h0, tog}, 32'hFFE);
    check({31'h0, lock}, 32'h1);
    apb(1'b1, ADDR_GATE, 32'hFFF, '0, 1'b0);
    watch(600);
    check({20'h0, tog}, 32'hFFF);
    check({31'h0, lock}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'hD, '0, 1'b0);
    apb(1'b1, ADDR_GATE, 32'hEFF, '0, 1'b0);
    watch(300);
    apb(1'b1, ADDR_GATE, 32'hFFF, '0, 1'b0);
    wait_lock(1'b0);
    wait_lock(1'b1);
    apb(1'b1, ADDR_CTRL, 32'h5, '0, 1'b0);
    pll_enable_pin <= 1'b0;
    watch(5);
    watch(300);
    check({20'h0, tog | clk_out}, 32'h0);
    check({31'h0, lock}, 32'h0);
    pll_enable_pin <= 1'b1;
    wait_lock(1'b1);
    watch(600);
    check({20'h0, tog}, 32'hFFF);
    apb(1'b1, ADDR_CTRL, 32'h4, '0, 1'b0);
    pll_enable_pin <= 1'b0;
    watch(600);
    check({20'h0, tog}, 32'hFFF);
    check({31'h0, lock}, 32'h1);
    pll_enable_pin <= 1'b1;
    // Gates stay closed across the reset so that relock overshoot never reaches a port.
    apb(1'b1, ADDR_GATE, 32'h0, '0, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h7, '0, 1'b0);
    watch(5);
    watch(300);
    check({20'h0, tog | clk_out}, 32'h0);
    apb(1'b0, ADDR_STAT, {16'h0, NOM_CODE, 8'h0}, 32'hFF01, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h5, '0, 1'b0);
    wait_lock(1'b1);
    apb(1'b1, ADDR_GATE, 32'hFFF, '0, 1'b0);
    watch(600);
    check({20'h0, tog}, 32'hFFF);
    apb(1'b1, ADDR_CTRL, 32'h1, '0, 1'b0);
    wait_lock(1'b0);
    watch(600);
    check({20'h0, tog}, 32'hFFF);
    apb(1'b1, ADDR_CTRL, 32'h11, '0, 1'b0);
    wait_lock(1'b1);
    ref_stop <= 1'b1;
    wait_lock(1'b0);
    watch(600);
    check({20'h0, tog}, 32'hFFF);
    ref_stop <= 1'b0;
    apb(1'b1, ADDR_DIV0 + 8'h10, 32'h10000, '0, 1'b0);
    watch(200);
    check({31'h0, tog[4]}, 32'h1);
    conclude();
  end
endmodule
